// file: lin_master_model.sv
`timescale 1ns/1ps
module lin_master_model
(
    input wire aclk,
    output logic line_ff
);
    initial line_ff = 1'b1;
    task automatic hold_bits(input logic lvl, input int n, input int per);
        line_ff <= lvl;
        repeat (n * per) @(posedge aclk);
    endtask
    task automatic send_break(input int per);
        hold_bits(1'b0, 13, per);
        hold_bits(1'b1, 2, per);
    endtask
    task automatic send_byte(input logic [7:0] b, input int per);
        int i;
        hold_bits(1'b0, 1, per);
        for (i = 0; i < 8; i++)
            hold_bits(b[i], 1, per);
        hold_bits(1'b1, 2, per);
    endtask
endmodule // lin_master_model

// file: lin_slave_hdr.v
`timescale 1ns/1ps
`include "lin_slave_regs.vh"

// Summary of operation
// - Header timeout supervision runs when identifier detection or auto synch is on.
// - Header longer than 57 slave bit times sets the header error flag.
// - Timer starts at break; stops at identifier, other header error, synch abort.
// - Timeout in synch field with auto synch blocks and sets synch state flag.
// - Other timeouts discard the header and resume searching for a break.
// - Header length is readable, only when identifier detection or auto synch is on.
// - Mute with identifier detection: header errors flag but never wake.
// - In mute mode framing errors on characters other than break and synch field are dropped silently.
// - Identifier mode wakes only after break, clean synch, clean identifier, no timeout.
// - Auto synch counts cycles over five falling edges, then updates the divider.
// - Character machine halts and delivers nothing during synch measurement.
// - Slave mode uses one divider, rate is clock over sixteen times divider.
// - Divider is unsigned fixed point: 8-bit mantissa, 4-bit fraction.
// - Three divider values are kept: nominal, measured and active.
// - Mantissa write with update method 0 beats a measured transfer in the same cycle.
// - Sixteen samples per bit; bit value is majority of samples 8 to 10.
// - Sampling phase realigns on every detected start bit.
// - Synch measurement counter and edge detection run on the system clock.
// - Break needs at least 11 low bit times; nine low bits are no break.
// - Update method 0 loads on mantissa write; 1 loads at next received character.
// - Header detection method 0 is break only, 1 is full identifier detection.
module lin_slave_hdr
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire receive_input_line,
    output wire tx_baud_tick
);

localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_START = 7'h02;
localparam [6:0] ST_DATA = 7'h04;
localparam [6:0] ST_STOP = 7'h08;
localparam [6:0] ST_SWAIT = 7'h10;
localparam [6:0] ST_SYNC = 7'h20;
localparam [6:0] ST_BLOCK = 7'h40;

function [5:0] lin_dec;
    input [7:0] a;
    begin
        case (a)
            `LIN_A_CTRL: lin_dec = 6'h01;
            `LIN_A_STAT: lin_dec = 6'h02;
            `LIN_A_DATA: lin_dec = 6'h04;
            `LIN_A_MANT: lin_dec = 6'h08;
            `LIN_A_FRAC: lin_dec = 6'h10;
            `LIN_A_HLEN: lin_dec = 6'h20;
            default: lin_dec = 6'h00;
        endcase
    end
endfunction

// Bus slave state
reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
reg [1:0] bresp_ff, rresp_ff;
reg [31:0] rdata_ff;
reg [7:0] aw_addr_ff, w_data_ff;
reg w_be_ff, armed_ff;

// Line and baud state
reg rx_meta_ff, rx_sync_ff, rx_prev_ff, tick_ff;
reg [12:0] acc_ff;
reg [3:0] tcnt_ff;
reg [7:0] low_ff;

// Receiver and header state
reg [6:0] state_ff, nxt_state;
reg [3:0] ph_ff, nxt_ph;
reg [1:0] votes_ff, nxt_votes;
reg [2:0] bitn_ff, nxt_bitn;
reg [7:0] shift_ff, nxt_shift;
reg [1:0] fld_ff, nxt_fld;
reg [14:0] sm_ff, nxt_sm;
reg [2:0] edg_ff, nxt_edg;
reg [5:0] hlen_ff, nxt_hlen;
reg run_ff, nxt_run;
reg [7:0] data_ff, nxt_data;
reg rdrf_ff, nxt_rdrf, fe_ff, nxt_fe, he_ff, nxt_he;
reg slv_ff, nxt_slv, ase_ff, nxt_ase, hdm_ff, nxt_hdm;
reg dum_ff, nxt_dum, mute_ff, nxt_mute, ssf_ff, nxt_ssf;
reg [11:0] nom_ff, nxt_nom, meas_ff, nxt_meas, act_ff, nxt_act;

reg [12:0] nxt_acc;
reg s_tick, ev_brk, ev_chr, ev_bad, bitv, xfer, set_he, meas_ld, deliver;
reg [7:0] xfer_val;

wire wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
wire [5:0] wr_dec = lin_dec(aw_addr_ff);
wire [5:0] wr_sel = wr_dec & {6{wr_go & w_be_ff}};
wire rd_go = s_axi_arvalid & arready_ff;
wire [5:0] rd_dec = lin_dec(s_axi_araddr);
wire [5:0] rd_sel = rd_dec & {6{rd_go}};
wire rx_fall = rx_prev_ff & ~rx_sync_ff;
wire hdr_act = hdm_ff | ase_ff;
wire [12:0] acc_sum = acc_ff + `LIN_OVS_STEP;
wire b_tick = s_tick & (tcnt_ff == `LIN_SMP_LAST);
wire ssf_clr = wr_sel[`LIN_R_CTRL] & ~w_data_ff[`LIN_C_SSF] & ssf_ff;
wire clr_seq = rd_sel[`LIN_R_DATA] & armed_ff;

assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_arready = arready_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;
assign s_axi_rvalid = rvalid_ff;
assign tx_baud_tick = tick_ff;

always @*
begin
    s_tick = 1'b0;
    nxt_acc = acc_sum;
    if (!slv_ff)
        nxt_acc = 13'h0000;
    else if (act_ff < `LIN_OVS_MIN)
    begin
        s_tick = 1'b1;
        nxt_acc = 13'h0000;
    end
    else if (acc_sum >= {1'b0, act_ff})
    begin
        s_tick = 1'b1;
        nxt_acc = acc_sum - {1'b0, act_ff};
    end
end

always @*
begin
    nxt_state = state_ff;
    nxt_ph = ph_ff;
    nxt_votes = votes_ff;
    nxt_bitn = bitn_ff;
    nxt_shift = shift_ff;
    nxt_fld = fld_ff;
    nxt_sm = sm_ff;
    nxt_edg = edg_ff;
    nxt_hlen = hlen_ff;
    nxt_run = run_ff;
    nxt_data = data_ff;
    nxt_meas = meas_ff;
    nxt_act = act_ff;
    nxt_nom = nom_ff;
    ev_brk = 1'b0;
    ev_chr = 1'b0;
    ev_bad = 1'b0;
    xfer = 1'b0;
    xfer_val = shift_ff;
    set_he = 1'b0;
    meas_ld = 1'b0;
    deliver = 1'b0;
    // majority of samples 8, 9 and 10
    bitv = ((votes_ff + {1'b0, rx_sync_ff}) >= 2'h2);
    nxt_rdrf = clr_seq ? 1'b0 : rdrf_ff;
    nxt_fe = clr_seq ? 1'b0 : fe_ff;
    nxt_he = (clr_seq & ~ssf_ff) ? 1'b0 : he_ff;
    nxt_slv = slv_ff;
    nxt_ase = ase_ff;
    nxt_hdm = hdm_ff;
    nxt_dum = dum_ff;
    nxt_mute = mute_ff;
    nxt_ssf = ssf_clr ? 1'b0 : ssf_ff;
    if (wr_sel[`LIN_R_CTRL])
    begin
        nxt_slv = w_data_ff[`LIN_C_SLV];
        nxt_ase = w_data_ff[`LIN_C_ASE];
        nxt_hdm = w_data_ff[`LIN_C_HDM];
        nxt_dum = w_data_ff[`LIN_C_DUM];
        if (!rdrf_ff)
            nxt_mute = w_data_ff[`LIN_C_MUTE];
    end
    if (wr_sel[`LIN_R_MANT])
        nxt_nom = {w_data_ff, nom_ff[3:0]};
    if (wr_sel[`LIN_R_FRAC])
        nxt_nom = {nom_ff[11:4], w_data_ff[3:0]};

    case (state_ff)
        ST_IDLE:
        begin
            if (slv_ff && rx_fall)
            begin
                nxt_state = ST_START;
                nxt_ph = 4'h0;
                nxt_votes = 2'h0;
            end
        end
        ST_START, ST_DATA, ST_STOP:
        begin
            if (s_tick)
            begin
                nxt_ph = ph_ff + 4'h1;
                if (ph_ff == `LIN_SMP_A || ph_ff == `LIN_SMP_B)
                    nxt_votes = votes_ff + {1'b0, rx_sync_ff};
                if (ph_ff == `LIN_SMP_LAST)
                    nxt_votes = 2'h0;
                if (ph_ff == `LIN_SMP_C)
                begin
                    if (state_ff == ST_START && bitv)
                        nxt_state = ST_IDLE;
                    if (state_ff == ST_DATA)
                        nxt_shift = {bitv, shift_ff[7:1]};
                    if (state_ff == ST_STOP)
                    begin
                        if (bitv)
                        begin
                            ev_chr = 1'b1;
                            nxt_state = ST_IDLE;
                        end
                        else
                            nxt_state = ST_SWAIT;
                    end
                end
                if (ph_ff == `LIN_SMP_LAST)
                begin
                    if (state_ff == ST_START)
                    begin
                        nxt_state = ST_DATA;
                        nxt_bitn = 3'h0;
                    end
                    if (state_ff == ST_DATA)
                    begin
                        if (bitn_ff == `LIN_BIT_LAST)
                            nxt_state = ST_STOP;
                        else
                            nxt_bitn = bitn_ff + 3'h1;
                    end
                end
            end
        end
        ST_SWAIT:
        begin
            // break only after eleven low bit times
            if (rx_sync_ff)
            begin
                nxt_state = ST_IDLE;
                if (low_ff >= `LIN_BRK_TICKS)
                    ev_brk = 1'b1;
                else
                begin
                    ev_chr = 1'b1;
                    ev_bad = |shift_ff;
                end
            end
        end
        ST_SYNC:
        begin
            if (rx_fall)
            begin
                nxt_edg = edg_ff + 3'h1;
                // First edge counts as cycle one so the span is the full edge distance
                if (edg_ff == 3'h0)
                    nxt_sm = 15'h0001;
            end
            if (edg_ff != 3'h0)
            begin
                if (sm_ff == `LIN_SM_MAX)
                begin
                    set_he = 1'b1;
                    nxt_run = 1'b0;
                    nxt_state = ST_BLOCK;
                end
                else
                    nxt_sm = sm_ff + 15'h0001;
            end
            if (rx_fall && edg_ff == (`LIN_SYNC_EDGES - 3'h1))
            begin
                meas_ld = 1'b1;
                nxt_meas = sm_ff[14:3];
                nxt_ssf = 1'b0;
                nxt_fld = `LIN_FLD_ID;
                nxt_state = ST_IDLE;
            end
            if (ssf_clr)
            begin
                nxt_run = 1'b0;
                nxt_fld = `LIN_FLD_NONE;
                nxt_state = ST_IDLE;
            end
        end
        ST_BLOCK:
        begin
            if (!ssf_ff)
            begin
                nxt_state = ST_IDLE;
                nxt_fld = `LIN_FLD_NONE;
            end
        end
        default:
            nxt_state = ST_IDLE;
    endcase

    // mute drops plain characters and their framing errors
    deliver = ev_chr & (~hdm_ff | (fld_ff == `LIN_FLD_NONE)) & ~mute_ff;
    if (deliver)
    begin
        xfer = 1'b1;
        nxt_fe = nxt_fe | ev_bad;
    end
    if (ev_chr && fld_ff == `LIN_FLD_SYNC)
    begin
        if (ev_bad || shift_ff != `LIN_SYNC_BYTE)
        begin
            set_he = 1'b1;
            nxt_run = 1'b0;
            nxt_fld = `LIN_FLD_NONE;
        end
        else
            nxt_fld = `LIN_FLD_ID;
    end
    if (ev_chr && fld_ff == `LIN_FLD_ID)
    begin
        nxt_run = 1'b0;
        nxt_fld = `LIN_FLD_NONE;
        if (hdm_ff && !ev_bad)
        begin
            xfer = 1'b1;
            nxt_mute = 1'b0;
        end
        else if (hdm_ff && !mute_ff)
            nxt_fe = 1'b1;
    end

    // one count per slave bit time
    if (run_ff && b_tick)
    begin
        nxt_hlen = hlen_ff + 6'h01;
        if (hlen_ff == `LIN_HDR_MAX)
        begin
            set_he = 1'b1;
            nxt_run = 1'b0;
            if (state_ff == ST_SYNC && ase_ff)
            begin
                nxt_state = ST_BLOCK;
                nxt_ssf = 1'b1;
            end
            else
            begin
                nxt_state = ST_IDLE;
                nxt_fld = `LIN_FLD_NONE;
                xfer = 1'b0;
                nxt_mute = mute_ff;
            end
        end
    end

    if (ev_brk)
    begin
        // timer only with a header mode on
        nxt_fld = `LIN_FLD_SYNC;
        nxt_hlen = 6'h00;
        nxt_run = hdr_act;
        if (ase_ff)
        begin
            nxt_state = ST_SYNC;
            nxt_ssf = 1'b1;
            nxt_edg = 3'h0;
            nxt_sm = 15'h0000;
        end
        if (!hdm_ff)
        begin
            xfer = 1'b1;
            xfer_val = 8'h00;
            nxt_mute = 1'b0;
        end
    end

    if (xfer)
    begin
        nxt_data = xfer_val;
        nxt_rdrf = 1'b1;
    end
    if (set_he)
        nxt_he = 1'b1;

    if (meas_ld)
        nxt_act = nxt_meas;
    if (xfer && dum_ff)
    begin
        nxt_act = nom_ff;
        nxt_dum = 1'b0;
    end
    if (wr_sel[`LIN_R_MANT] && !dum_ff)
        nxt_act = {w_data_ff, nom_ff[3:0]};
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        rx_meta_ff <= 1'b1;
        rx_sync_ff <= 1'b1;
        rx_prev_ff <= 1'b1;
        tick_ff <= 1'b0;
        acc_ff <= 13'h0000;
        tcnt_ff <= 4'h0;
        low_ff <= 8'h00;
        state_ff <= ST_IDLE;
        ph_ff <= 4'h0;
        votes_ff <= 2'h0;
        bitn_ff <= 3'h0;
        shift_ff <= 8'h00;
        fld_ff <= `LIN_FLD_NONE;
        sm_ff <= 15'h0000;
        edg_ff <= 3'h0;
        hlen_ff <= 6'h00;
        run_ff <= 1'b0;
        data_ff <= 8'h00;
        rdrf_ff <= 1'b0;
        fe_ff <= 1'b0;
        he_ff <= 1'b0;
        slv_ff <= 1'b0;
        ase_ff <= 1'b0;
        hdm_ff <= 1'b0;
        dum_ff <= 1'b0;
        mute_ff <= 1'b0;
        ssf_ff <= 1'b0;
        nom_ff <= {`LIN_RST_MANT, `LIN_RST_FRAC};
        meas_ff <= {`LIN_RST_MANT, `LIN_RST_FRAC};
        act_ff <= {`LIN_RST_MANT, `LIN_RST_FRAC};
    end
    else
    begin
        rx_meta_ff <= receive_input_line;
        rx_sync_ff <= rx_meta_ff;
        rx_prev_ff <= rx_sync_ff;
        tick_ff <= s_tick;
        acc_ff <= nxt_acc;
        if (s_tick)
            tcnt_ff <= tcnt_ff + 4'h1;
        if (rx_sync_ff)
            low_ff <= 8'h00;
        else if (s_tick && low_ff != `LIN_LOW_MAX)
            low_ff <= low_ff + 8'h01;
        state_ff <= nxt_state;
        ph_ff <= nxt_ph;
        votes_ff <= nxt_votes;
        bitn_ff <= nxt_bitn;
        shift_ff <= nxt_shift;
        fld_ff <= nxt_fld;
        sm_ff <= nxt_sm;
        edg_ff <= nxt_edg;
        hlen_ff <= nxt_hlen;
        run_ff <= nxt_run;
        data_ff <= nxt_data;
        rdrf_ff <= nxt_rdrf;
        fe_ff <= nxt_fe;
        he_ff <= nxt_he;
        slv_ff <= nxt_slv;
        ase_ff <= nxt_ase;
        hdm_ff <= nxt_hdm;
        dum_ff <= nxt_dum;
        mute_ff <= nxt_mute;
        ssf_ff <= nxt_ssf;
        nom_ff <= nxt_nom;
        meas_ff <= nxt_meas;
        act_ff <= nxt_act;
    end
end

// Register bus slave
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
        bvalid_ff <= 1'b0;
        bresp_ff <= `LIN_RESP_OKAY;
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
        rdata_ff <= 32'h00000000;
        rresp_ff <= `LIN_RESP_OKAY;
        aw_addr_ff <= 8'h00;
        w_data_ff <= 8'h00;
        w_be_ff <= 1'b0;
        armed_ff <= 1'b0;
    end
    else
    begin
        if (s_axi_awvalid && awready_ff)
        begin
            aw_addr_ff <= s_axi_awaddr;
            awready_ff <= 1'b0;
        end
        if (s_axi_wvalid && wready_ff)
        begin
            w_data_ff <= s_axi_wdata[7:0];
            w_be_ff <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
        end
        if (wr_go)
        begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_dec == 6'h00) ? `LIN_RESP_SLVERR : `LIN_RESP_OKAY;
        end
        else if (bvalid_ff && s_axi_bready)
            bvalid_ff <= 1'b0;
        if (rd_go)
        begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= (rd_dec == 6'h00) ? `LIN_RESP_SLVERR : `LIN_RESP_OKAY;
            if (rd_sel[`LIN_R_STAT])
                armed_ff <= 1'b1;
            else if (rd_sel[`LIN_R_DATA])
                armed_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            if (rd_sel[`LIN_R_CTRL])
                rdata_ff[5:0] <= {ssf_ff, mute_ff, dum_ff, hdm_ff, ase_ff, slv_ff};
            if (rd_sel[`LIN_R_STAT])
                rdata_ff[2:0] <= {he_ff, fe_ff, rdrf_ff};
            if (rd_sel[`LIN_R_DATA])
                rdata_ff[7:0] <= data_ff;
            if (rd_sel[`LIN_R_MANT])
                rdata_ff[7:0] <= act_ff[11:4];
            if (rd_sel[`LIN_R_FRAC])
                rdata_ff[3:0] <= act_ff[3:0];
            // length visible only with a header mode on
            if (rd_sel[`LIN_R_HLEN])
                rdata_ff[5:0] <= hlen_ff & {6{hdr_act}};
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
end

endmodule // lin_slave_hdr

// file: lin_slave_header_timer_autobaud_test.sv
`timescale 1ns/1ps
`include "lin_slave_regs.vh"
module lin_slave_header_timer_autobaud_test;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire receive_input_line, tx_baud_tick;
    logic [1:0] rresp_q, bresp_q;
    int num_errors = 0, comparisons = 0;
    always #4 aclk = ~aclk;
    lin_slave_hdr DUT (.*);
    lin_master_model MASTER (.aclk(aclk), .line_ff(receive_input_line));
    task automatic wrap_up;
        $display("Mismatches %0d of %0d comparisons", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic got;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        got = 1'b0;
        for (n = 0; n < 200 && !got; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                got = 1'b1;
                bresp_q = s_axi_bresp;
            end
        end
        s_axi_bready <= 1'b0;
        if (!got)
        begin
            num_errors++;
            wrap_up;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        logic got;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        got = 1'b0;
        for (n = 0; n < 200 && !got; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                got = 1'b1;
                d = s_axi_rdata;
                rresp_q = s_axi_rresp;
            end
        end
        s_axi_rready <= 1'b0;
        if (!got)
        begin
            num_errors++;
            wrap_up;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        axi_rd(a, d);
        chk(d, e);
    endtask
    task automatic reset_values;
        rc(`LIN_A_CTRL, 32'h00000000);
        rc(`LIN_A_STAT, 32'h00000000);
        rc(`LIN_A_MANT, 32'h00000001);
        rc(`LIN_A_FRAC, 32'h00000000);
        rc(`LIN_A_HLEN, 32'h00000000);
        rc(8'h40, 32'h00000000);
        chk(rresp_q, `LIN_RESP_SLVERR);
        axi_wr(8'h40, 32'h00000000);
        chk(bresp_q, `LIN_RESP_SLVERR);
    endtask
    // Break with no synch: header error after 57 bit times, mute kept
    task automatic timeout_in_mute;
        axi_wr(`LIN_A_CTRL, 32'h00000015);
        MASTER.send_break(16);
        MASTER.hold_bits(1'b1, 70, 16);
        rc(`LIN_A_STAT, 32'h00000004);
        rc(`LIN_A_CTRL, 32'h00000015);
        rc(`LIN_A_DATA, 32'h00000000);
        rc(`LIN_A_STAT, 32'h00000000);
    endtask
    task automatic wake_header;
        logic [31:0] hl;
        MASTER.send_break(16);
        MASTER.send_byte(`LIN_SYNC_BYTE, 16);
        MASTER.send_byte(8'h3C, 16);
        rc(`LIN_A_STAT, 32'h00000001);
        rc(`LIN_A_CTRL, 32'h00000005);
        rc(`LIN_A_DATA, 32'h0000003C);
        axi_rd(`LIN_A_HLEN, hl);
        chk(hl >= 32'h00000014 && hl <= 32'h0000001C, 32'h00000001);
    endtask
    // Synch at half the nominal rate doubles the divider
    task automatic auto_synch;
        int c;
        axi_wr(`LIN_A_CTRL, 32'h00000003);
        MASTER.send_break(16);
        rc(`LIN_A_STAT, 32'h00000001);
        rc(`LIN_A_DATA, 32'h00000000);
        MASTER.send_byte(`LIN_SYNC_BYTE, 32);
        rc(`LIN_A_STAT, 32'h00000000);
        MASTER.send_byte(8'h3C, 32);
        rc(`LIN_A_STAT, 32'h00000001);
        rc(`LIN_A_DATA, 32'h0000003C);
        rc(`LIN_A_MANT, 32'h00000002);
        rc(`LIN_A_FRAC, 32'h00000000);
        c = 0;
        repeat (64)
        begin
            @(posedge aclk);
            if (tx_baud_tick === 1'b1)
                c++;
        end
        chk(c, 32);
    endtask
    task automatic deferred_update;
        axi_wr(`LIN_A_CTRL, 32'h00000009);
        axi_wr(`LIN_A_MANT, 32'h00000001);
        chk(bresp_q, `LIN_RESP_OKAY);
        rc(`LIN_A_MANT, 32'h00000002);
        MASTER.send_byte(8'hA5, 32);
        rc(`LIN_A_MANT, 32'h00000001);
        rc(`LIN_A_CTRL, 32'h00000001);
        rc(`LIN_A_DATA, 32'h000000A5);
    endtask
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        reset_values;
        timeout_in_mute;
        wake_header;
        auto_synch;
        deferred_update;
        wrap_up;
    end
endmodule // lin_slave_header_timer_autobaud_test

// file: lin_slave_monitor.sv
`timescale 1ns/1ps
`include "lin_slave_regs.vh"
module lin_slave_monitor
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking mon_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    r_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer late");
    r_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    unmapped_rd_a: assert property (ar_take && s_axi_araddr > `LIN_A_HLEN
        |=> s_axi_rresp == `LIN_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    hlen_width_a: assert property (ar_take && s_axi_araddr == `LIN_A_HLEN
        |=> s_axi_rdata[31:6] == 26'h0000000)
        else $error("header length too wide");
    mant_width_a: assert property (ar_take && s_axi_araddr == `LIN_A_MANT
        |=> s_axi_rdata[31:8] == 24'h000000)
        else $error("mantissa too wide");
    frac_width_a: assert property (ar_take && s_axi_araddr == `LIN_A_FRAC
        |=> s_axi_rdata[31:4] == 28'h0000000)
        else $error("fraction too wide");
endmodule // lin_slave_monitor
bind lin_slave_hdr lin_slave_monitor MON (.*);

// file: lin_slave_regs.vh
`ifndef LIN_SLAVE_REGS_VH
`define LIN_SLAVE_REGS_VH

// Register byte addresses
`define LIN_A_CTRL 8'h00
`define LIN_A_STAT 8'h04
`define LIN_A_DATA 8'h08
`define LIN_A_MANT 8'h0C
`define LIN_A_FRAC 8'h10
`define LIN_A_HLEN 8'h14

// One-hot decode positions
`define LIN_R_CTRL 0
`define LIN_R_STAT 1
`define LIN_R_DATA 2
`define LIN_R_MANT 3
`define LIN_R_FRAC 4
`define LIN_R_HLEN 5

// Control register fields
`define LIN_C_SLV 0
`define LIN_C_ASE 1
`define LIN_C_HDM 2
`define LIN_C_DUM 3
`define LIN_C_MUTE 4
`define LIN_C_SSF 5

// Status register fields
`define LIN_S_RDRF 0
`define LIN_S_FE 1
`define LIN_S_HE 2

// Reset values
`define LIN_RST_MANT 8'h01
`define LIN_RST_FRAC 4'h0

// Timing and framing
`define LIN_OVS_STEP 13'h0010
`define LIN_OVS_MIN 12'h010
`define LIN_SMP_A 4'h7
`define LIN_SMP_B 4'h8
`define LIN_SMP_C 4'h9
`define LIN_SMP_LAST 4'hF
`define LIN_BIT_LAST 3'h7
`define LIN_BRK_BITS 8'h0B
`define LIN_BRK_TICKS (`LIN_BRK_BITS * 8'h10)
`define LIN_LOW_MAX 8'hFF
`define LIN_HDR_MAX 6'h39
`define LIN_SYNC_BYTE 8'h55
`define LIN_SYNC_EDGES 3'h5
`define LIN_SM_MAX 15'h7FFF

// Header field tracking
`define LIN_FLD_NONE 2'h0
`define LIN_FLD_SYNC 2'h1
`define LIN_FLD_ID 2'h2

// Bus responses
`define LIN_RESP_OKAY 2'h0
`define LIN_RESP_SLVERR 2'h2

`endif
